/* rtl/prio_regs.sv */
// Top: software-visible priority control word for four interrupt sources
//
// Function
// - A zero priority code disables its source regardless of flag or enable.
// - Nonzero priority codes select levels one through seven by binary value.
// - Each source has a two-bit sublevel, zero through three.
// - Bits outside the fields ignore writes and read zero.
// - Source three priority sits at bits 28 to 26.
// - Source three sublevel sits at bits 25 to 24.
// - Source two priority sits at bits 20 to 18.
// - Source two sublevel sits at bits 17 to 16.
// - Source one priority sits at bits 12 to 10.
//
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
module prio_regs
  import prio_pkg::*;
(
  // Clock and reset
  input  wire logic                          I_CLK,
  input  wire logic                          I_RESET,
  // Avalon-MM slave
  input  wire logic [prio_pkg::ADDR_W-1:0]   i_address,
  input  wire logic                          i_read,
  input  wire logic                          i_write,
  input  wire logic [3:0]                    i_byteenable,
  input  wire logic [prio_pkg::DATA_W-1:0]   i_writedata,
  output logic      [prio_pkg::DATA_W-1:0]   o_readdata,
  output logic                               o_waitrequest,
  // Per-source priority outputs to the arbiter
  input  wire logic [prio_pkg::NUM_SRC-1:0]  i_src_req,
  output logic      [prio_pkg::NUM_SRC*3-1:0] o_level,
  output logic      [prio_pkg::NUM_SRC*2-1:0] o_sublevel,
  output logic      [prio_pkg::NUM_SRC-1:0]  o_src_active
);

  // ----------------------------------------------------------------------
  // Storage and wires
  // ----------------------------------------------------------------------
  logic [31:0]        ctrl_r;
  logic [31:0]        ctrl_nxt;
  logic [31:0]        rdata_r;
  logic [31:0]        rdata_nxt;
  logic [31:0]        be_mask;
  logic [31:0]        stat_word;
  logic               accept;
  logic               hit_ctrl;
  logic               hit_stat;
  logic               wr_ctrl;
  logic [NUM_SRC-1:0] enabled;
  logic [2:0]         lvl [NUM_SRC];
  logic [1:0]         sub [NUM_SRC];
  logic [2:0]         top_level;

  // Expand byte enables to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h00000000;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{be[b]}};
    end
    return m;
  endfunction : lane_mask

  // ----------------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------------
  prio_bus_slave u_slave (
    .I_CLK         (I_CLK),
    .I_RESET       (I_RESET),
    .i_read        (i_read),
    .i_write       (i_write),
    .o_waitrequest (o_waitrequest),
    .o_accept      (accept)
  );

  // ----------------------------------------------------------------------
  // Address decode and write merge
  // ----------------------------------------------------------------------
  // Only implemented bits are taken; the rest stay zero
  assign hit_ctrl = (i_address == PRIO_CTRL_OFS);
  assign hit_stat = (i_address == PRIO_STAT_OFS);
  assign wr_ctrl  = accept & i_write & hit_ctrl;
  assign be_mask  = lane_mask(i_byteenable) & IMPL_MASK;
  assign ctrl_nxt = (ctrl_r & ~be_mask) | (i_writedata & be_mask);

  // Control word; reset leaves every source disabled
  always_ff @(posedge I_CLK) begin
    if (I_RESET)      ctrl_r <= CTRL_RESET;
    else if (wr_ctrl) ctrl_r <= ctrl_nxt;
  end

  // ----------------------------------------------------------------------
  // Per-lane decode
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
    prio_field_decode u_dec (
      .i_lane     (ctrl_r[g*LANE_W +: LANE_W]),
      .o_level    (lvl[g]),
      .o_sublevel (sub[g]),
      .o_enabled  (enabled[g])
    );
    assign o_level[g*3 +: 3]    = lvl[g];
    assign o_sublevel[g*2 +: 2] = sub[g];
  end

  // A disabled source never reaches the arbiter
  assign o_src_active = i_src_req & enabled;

  // Highest level among enabled sources, shown in the status word
  always_comb begin
    top_level = LEVEL_OFF;
    for (int s = 0; s < NUM_SRC; s++) begin
      if (enabled[s] && (lvl[s] > top_level)) top_level = lvl[s];
    end
  end

  assign stat_word = {21'h000000, top_level, 4'h0, enabled};

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  // Unmapped addresses read zero and writes there are dropped
  assign rdata_nxt = hit_ctrl ? (ctrl_r & IMPL_MASK) :
                     hit_stat ? stat_word : READ_UNMAPPED;

  // Registered read data, reloaded every cycle; the address stands from the
  // idle cycle on, so the copy taken then is the answer in the wait cycle
  always_ff @(posedge I_CLK) begin
    if (I_RESET) rdata_r <= READ_UNMAPPED;
    else         rdata_r <= rdata_nxt;
  end

  // Data output from a flip-flop; the wait cycle hides the extra stage
  assign o_readdata = rdata_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);

  chk_unimpl_zero: assert property (
    (ctrl_r & ~IMPL_MASK) == 32'h00000000)
    else $error("Unimplemented control bits are set");

  chk_disabled_quiet: assert property (
    (ctrl_r[4:2] == 3'h0) |-> !o_src_active[0])
    else $error("Disabled source zero requests service");

  chk_active_pass: assert property (
    (ctrl_r[28:26] != 3'h0 && i_src_req[3]) |-> o_src_active[3])
    else $error("Enabled source three is blocked");

  chk_level_three: assert property (
    o_level[11:9] == ctrl_r[28:26])
    else $error("Source three level misplaced");

  chk_sub_three: assert property (
    o_sublevel[7:6] == ctrl_r[25:24])
    else $error("Source three sublevel misplaced");

  chk_level_two: assert property (
    $past(wr_ctrl) && $past(i_byteenable[2]) |->
      o_level[8:6] == $past(i_writedata[20:18]))
    else $error("Source two level not written");

  chk_sub_two: assert property (
    $past(wr_ctrl) && $past(i_byteenable[2]) |->
      o_sublevel[5:4] == $past(i_writedata[17:16]))
    else $error("Source two sublevel not written");

  chk_level_one: assert property (
    $past(wr_ctrl) && $past(i_byteenable[1]) |->
      ctrl_r[12:10] == $past(i_writedata[12:10]))
    else $error("Source one level not written");

  chk_low_lanes: assert property (
    o_level[2:0] == ctrl_r[4:2] && o_sublevel[1:0] == ctrl_r[1:0]
      && o_sublevel[3:2] == ctrl_r[9:8])
    else $error("Low lane fields misplaced");

  // Reset clears the word without a write, so the edge after it is exempt
  chk_hold_nowrite: assert property (
    !$past(wr_ctrl) && !$past(I_RESET) |-> $stable(ctrl_r))
    else $error("Control word changed without a write");

  chk_wait_once: assert property (
    (i_read || i_write) && o_waitrequest && !$past(accept)
      ##1 (i_read || i_write) |-> !o_waitrequest)
    else $error("Waitrequest held longer than one cycle");

  chk_read_ctrl: assert property (
    accept && i_read && hit_ctrl |-> o_readdata == (ctrl_r & IMPL_MASK))
    else $error("Control read data wrong");

  // ----------------------------------------------------------------------
  // Field placement on the arbiter outputs
  // ----------------------------------------------------------------------
  chk_level_two_pos: assert property (
    o_level[8:6] == ctrl_r[20:18])
    else $error("Source two level misplaced");

  chk_sub_two_pos: assert property (
    o_sublevel[5:4] == ctrl_r[17:16])
    else $error("Source two sublevel misplaced");

  chk_level_one_pos: assert property (
    o_level[5:3] == ctrl_r[12:10])
    else $error("Source one level misplaced");

  // ----------------------------------------------------------------------
  // Writes land in the enabled lanes and nowhere else
  // ----------------------------------------------------------------------
  chk_level_zero_wr: assert property (
    $past(wr_ctrl) && $past(i_byteenable[0]) |->
      o_level[2:0] == $past(i_writedata[4:2]))
    else $error("Source zero level not written");

  chk_sub_zero_wr: assert property (
    $past(wr_ctrl) && $past(i_byteenable[0]) |->
      o_sublevel[1:0] == $past(i_writedata[1:0]))
    else $error("Source zero sublevel not written");

  chk_sub_one_wr: assert property (
    $past(wr_ctrl) && $past(i_byteenable[1]) |->
      o_sublevel[3:2] == $past(i_writedata[9:8]))
    else $error("Source one sublevel not written");

  chk_level_three_wr: assert property (
    $past(wr_ctrl) && $past(i_byteenable[3]) |->
      o_level[11:9] == $past(i_writedata[28:26]))
    else $error("Source three level not written");

  chk_sub_three_wr: assert property (
    $past(wr_ctrl) && $past(i_byteenable[3]) |->
      o_sublevel[7:6] == $past(i_writedata[25:24]))
    else $error("Source three sublevel not written");

  chk_lane_zero_kept: assert property (
    $past(wr_ctrl) && !$past(i_byteenable[0]) |-> $stable(ctrl_r[7:0]))
    else $error("Lane zero changed without its byte enable");

  chk_lane_one_kept: assert property (
    $past(wr_ctrl) && !$past(i_byteenable[1]) |-> $stable(ctrl_r[15:8]))
    else $error("Lane one changed without its byte enable");

  chk_lane_two_kept: assert property (
    $past(wr_ctrl) && !$past(i_byteenable[2]) |-> $stable(ctrl_r[23:16]))
    else $error("Lane two changed without its byte enable");

  chk_lane_three_kept: assert property (
    $past(wr_ctrl) && !$past(i_byteenable[3]) |-> $stable(ctrl_r[31:24]))
    else $error("Lane three changed without its byte enable");

  chk_stray_kept: assert property (
    $past(accept && i_write && !hit_ctrl && !I_RESET) |-> $stable(ctrl_r))
    else $error("Write elsewhere changed the control word");

  chk_reset_clear: assert property (
    $past(I_RESET) |-> ctrl_r == CTRL_RESET)
    else $error("Control word not cleared by reset");

  // ----------------------------------------------------------------------
  // Bus side: handshake and read data
  // ----------------------------------------------------------------------
  chk_wait_idle: assert property (
    !(i_read || i_write) |-> o_waitrequest)
    else $error("Waitrequest low with no request");

  chk_accept_once: assert property (
    accept |=> o_waitrequest)
    else $error("Accept stood longer than one cycle");

  chk_read_stat_en: assert property (
    accept && i_read && hit_stat |-> o_readdata[3:0] == enabled)
    else $error("Status enable bits wrong");

  chk_read_stat_top: assert property (
    accept && i_read && hit_stat |-> o_readdata[10:8] == top_level)
    else $error("Status top level wrong");

  chk_read_stat_pad: assert property (
    accept && i_read && hit_stat |->
      o_readdata[31:11] == 21'h000000 && o_readdata[7:4] == 4'h0)
    else $error("Status spare bits not zero");

  chk_read_unmapped: assert property (
    accept && i_read && !hit_ctrl && !hit_stat |-> o_readdata == READ_UNMAPPED)
    else $error("Unmapped read data not zero");

  // ----------------------------------------------------------------------
  // Disabled sources stay quiet, enabled ones rank by level
  // ----------------------------------------------------------------------
  chk_src_one_off: assert property (
    (ctrl_r[12:10] == 3'h0) |-> !o_src_active[1])
    else $error("Disabled source one requests service");

  chk_src_two_off: assert property (
    (ctrl_r[20:18] == 3'h0) |-> !o_src_active[2])
    else $error("Disabled source two requests service");

  chk_src_three_off: assert property (
    (ctrl_r[28:26] == 3'h0) |-> !o_src_active[3])
    else $error("Disabled source three requests service");

  chk_active_one: assert property (
    (ctrl_r[12:10] != 3'h0 && i_src_req[1]) |-> o_src_active[1])
    else $error("Enabled source one is blocked");

  chk_top_zero_src: assert property (
    enabled[0] |-> top_level >= lvl[0])
    else $error("Top level below source zero");

  chk_top_two_src: assert property (
    enabled[2] |-> top_level >= lvl[2])
    else $error("Top level below source two");

  cov_write: cover property (wr_ctrl);
  cov_read_stat: cover property (accept && i_read && hit_stat);
  cov_top_seven: cover property (top_level == 3'h7);
  cov_unmapped: cover property (accept && !hit_ctrl && !hit_stat);
  cov_src_masked: cover property (i_src_req[0] && !enabled[0]);

endmodule : prio_regs

/* include/prio_pkg.sv */
// Package: register map, field layout and timing for the priority control word
package prio_pkg;

  // ----------------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------------
  localparam int          ADDR_W       = 4;
  localparam int          DATA_W       = 32;
  localparam int          NUM_SRC      = 4;
  localparam int          LEVEL_W      = 3;
  localparam int          SUB_W        = 2;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [3:0]  PRIO_CTRL_OFS = 4'h0;  // priority_control_word
  localparam logic [3:0]  PRIO_STAT_OFS = 4'h4;  // Decoded enable and top level

  // ----------------------------------------------------------------------
  // Field layout: each source owns one byte lane
  // ----------------------------------------------------------------------
  localparam int          LANE_W       = 8;
  localparam int          LEVEL_LSB    = 2;
  localparam int          SUB_LSB      = 0;
  localparam logic [31:0] IMPL_MASK    = 32'h1f1f1f1f;
  localparam logic [31:0] CTRL_RESET   = 32'h00000000;
  localparam logic [31:0] READ_UNMAPPED = 32'h00000000;

  // ----------------------------------------------------------------------
  // Level codes
  // ----------------------------------------------------------------------
  localparam logic [2:0]  LEVEL_OFF    = 3'h0;

  // ----------------------------------------------------------------------
  // Slave timing: waitrequest stands for this many cycles on each access
  // ----------------------------------------------------------------------
  localparam int          WAIT_CYCLES  = 1;

  // Slave handshake states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b10
  } bus_state_t;

endpackage : prio_pkg

/* rtl/prio_field_decode.sv */
// Decoder: splits one byte lane into level, sublevel and enable
`timescale 1ns/1ps
module prio_field_decode
  import prio_pkg::*;
(
  // Lane contents
  input  wire logic [7:0]         i_lane,
  // Decoded fields
  output logic      [LEVEL_W-1:0] o_level,
  output logic      [SUB_W-1:0]   o_sublevel,
  output logic                    o_enabled
);

  // ----------------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------------
  // Level code equals its binary value, 1 through 7
  assign o_level    = i_lane[LEVEL_LSB +: LEVEL_W];
  assign o_sublevel = i_lane[SUB_LSB +: SUB_W];
  // A zero level masks the source outright
  assign o_enabled  = (o_level != LEVEL_OFF);

endmodule : prio_field_decode

/* rtl/prio_bus_slave.sv */
// Avalon-MM slave handshake: holds waitrequest for a fixed number of cycles
`timescale 1ns/1ps
module prio_bus_slave
  import prio_pkg::*;
(
  // Clock and reset
  input  wire logic I_CLK,
  input  wire logic I_RESET,
  // Request side
  input  wire logic i_read,
  input  wire logic i_write,
  // Handshake
  output logic      o_waitrequest,
  output logic      o_accept
);

  bus_state_t state_r;
  bus_state_t state_nxt;
  logic       req;

  // ----------------------------------------------------------------------
  // Handshake sequencing
  // ----------------------------------------------------------------------
  // One wait cycle, then accept; DONE lets the master drop its request
  assign req = i_read | i_write;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: if (req) state_nxt = ST_WAIT;
      ST_WAIT: state_nxt = ST_DONE;
      ST_DONE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) state_r <= ST_IDLE;
    else         state_r <= state_nxt;
  end

  // Accept in WAIT: the master sees waitrequest low at that edge
  assign o_accept      = (state_r == ST_WAIT) & req;
  assign o_waitrequest = ~o_accept;

endmodule : prio_bus_slave

/* verif/tb.sv */
// Testbench: bus access and field decode checks for the priority control word
`timescale 1ns/1ps
module tb;
  import prio_pkg::*;
  // ----------------------------------------------------------------------
  // Bench signals
  // ----------------------------------------------------------------------
  logic                 clk;
  logic                 reset;
  logic [ADDR_W-1:0]    address;
  logic                 read;
  logic                 write;
  logic [3:0]           byteenable;
  logic [DATA_W-1:0]    writedata;
  logic [DATA_W-1:0]    readdata;
  logic                 waitrequest;
  logic [NUM_SRC-1:0]   src_req;
  logic [NUM_SRC*3-1:0] level;
  logic [NUM_SRC*2-1:0] sublevel;
  logic [NUM_SRC-1:0]   src_active;
  int                   miscompares;
  int                   n_compared;
  logic [31:0]          rd;
  logic [31:0]          expw;
  logic [2:0]           lv;
  logic [1:0]           sv;
  // Field positions written out per source, not derived from the lane pattern
  int                   lvl_pos [4] = '{2, 10, 18, 26};
  int                   sub_pos [4] = '{0, 8, 16, 24};

  prio_regs i_dut (
    .I_CLK(clk), .I_RESET(reset), .i_address(address), .i_read(read),
    .i_write(write), .i_byteenable(byteenable), .i_writedata(writedata),
    .o_readdata(readdata), .o_waitrequest(waitrequest), .i_src_req(src_req),
    .o_level(level), .o_sublevel(sublevel), .o_src_active(src_active)
  );

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Entered just after a rising edge; one edge passes first so no signal is driven
  // twice in a time step, then the request holds until waitrequest is sampled low
  task automatic access(input logic is_rd, input logic [3:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] got);
    int n;
    n = 0;
    got = '0;
    @(posedge clk);
    address    <= a;
    read       <= is_rd;
    write      <= !is_rd;
    writedata  <= d;
    byteenable <= be;
    do begin
      @(posedge clk);
      n++;
      if (n > 20) begin
        miscompares++;
        $display("mismatch waitrequest expected 0 seen %b", waitrequest);
        complete_run();
      end
    end while (waitrequest !== 1'b0);
    // Read data stands at the accept edge and is taken there
    got = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : access

  task automatic bus_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] unused;
    access(1'b0, a, d, be, unused);
  endtask : bus_write

  task automatic bus_read(input logic [3:0] a, output logic [31:0] got);
    access(1'b1, a, 32'h00000000, 4'hf, got);
  endtask : bus_read

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    reset = 1'b1;
    address = '0;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'h0;
    writedata = '0;
    src_req = 4'hf;
    miscompares = 0;
    n_compared = 0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // Power-on state: everything cleared, nothing requests service
    bus_read(PRIO_CTRL_OFS, rd);
    check("word after reset", 32'h00000000, rd);
    check("active after reset", 32'h0, {28'h0, src_active});
    $display("test reset done");
    // All ones: only the field bits stick, every source shows level seven
    bus_write(PRIO_CTRL_OFS, 32'hffffffff, 4'hf);
    bus_read(PRIO_CTRL_OFS, rd);
    check("word all ones", 32'h1f1f1f1f, rd);
    check("levels all ones", 32'h00000fff, {20'h0, level});
    check("sublevels all ones", 32'h000000ff, {24'h0, sublevel});
    bus_read(PRIO_STAT_OFS, rd);
    check("status all ones", 32'h0000070f, rd);
    $display("test unimplemented done");
    // Every level and sublevel code on every source, with mixed requests
    for (int v = 0; v < 8; v++) begin
      expw = '0;
      src_req <= v[0] ? 4'hf : 4'h5;
      for (int g = 0; g < 4; g++) begin
        lv = 3'(v + g);
        sv = 2'(v + g);
        expw[lvl_pos[g] +: 3] = lv;
        expw[sub_pos[g] +: 2] = sv;
      end
      bus_write(PRIO_CTRL_OFS, expw, 4'hf);
      @(negedge clk);
      for (int g = 0; g < 4; g++) begin
        lv = 3'(v + g);
        sv = 2'(v + g);
        check("level", {29'h0, lv}, {29'h0, level[g*3 +: 3]});
        check("sublevel", {30'h0, sv}, {30'h0, sublevel[g*2 +: 2]});
        check("active", {31'h0, src_req[g] & (lv != 3'h0)}, {31'h0, src_active[g]});
      end
      @(posedge clk);
      bus_read(PRIO_CTRL_OFS, rd);
      check("word readback", expw, rd);
    end
    $display("test field layout done");
    // One lane written alone
    bus_write(PRIO_CTRL_OFS, 32'h00000000, 4'hf);
    bus_write(PRIO_CTRL_OFS, 32'hffffffff, 4'h4);
    bus_read(PRIO_CTRL_OFS, rd);
    check("single lane", 32'h001f0000, rd);
    bus_read(PRIO_STAT_OFS, rd);
    check("status single lane", 32'h00000704, rd);
    // Writes elsewhere leave the word alone; unmapped reads give zero
    bus_write(4'h8, 32'hffffffff, 4'hf);
    bus_write(PRIO_STAT_OFS, 32'hffffffff, 4'hf);
    bus_read(PRIO_CTRL_OFS, rd);
    check("word after stray writes", 32'h001f0000, rd);
    bus_read(4'h8, rd);
    check("unmapped read", READ_UNMAPPED, rd);
    $display("test address decode done");
    // Reset in mid-run clears the fields again
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    bus_read(PRIO_CTRL_OFS, rd);
    check("word after second reset", 32'h00000000, rd);
    check("levels after second reset", 32'h0, {20'h0, level});
    $display("test second reset done");
    complete_run();
  end
endmodule : tb
